// ---- src/gsr_pkg.sv ----
// shared constants and helpers for the gyro register serial link
package gsr_pkg;

  // frame layout
  localparam int         FRAME_BITS = 16;
  localparam logic [4:0] BIT_CNT_LAST = 5'h0F;
  localparam logic [4:0] BIT_CNT_FULL = 5'h10;
  localparam int         FR_RW      = 15;
  localparam int         FR_ADDR_HI = 14;
  localparam int         FR_ADDR_LO = 8;
  localparam int         FR_DATA_HI = 7;

  // synchroniser bit positions (device side)
  localparam int         SY_CS   = 2;
  localparam int         SY_SCLK = 1;
  localparam int         SY_MOSI = 0;
  localparam logic [2:0] SY_IDLE = 3'h6;

  // byte addresses, lower byte of each word
  localparam logic [6:0] A_FLASH_WRITE_COUNT = 7'h00;
  localparam logic [6:0] A_SUPPLY    = 7'h02;
  localparam logic [6:0] A_RATE      = 7'h04;
  localparam logic [6:0] A_AUX       = 7'h0A;
  localparam logic [6:0] A_TEMP      = 7'h0C;
  localparam logic [6:0] A_ANGLE     = 7'h0E;
  localparam logic [6:0] A_OFF       = 7'h14;
  localparam logic [6:0] A_SCALE     = 7'h16;
  localparam logic [6:0] A_MAG1      = 7'h20;
  localparam logic [6:0] A_MAG2      = 7'h22;
  localparam logic [6:0] A_SMPL1     = 7'h24;
  localparam logic [6:0] A_SMPL2     = 7'h26;
  localparam logic [6:0] A_ALARM_CONTROL  = 7'h28;
  localparam logic [6:0] A_DAC       = 7'h30;
  localparam logic [6:0] A_DIO       = 7'h32;
  localparam logic [6:0] A_MISC      = 7'h34;
  localparam logic [6:0] A_SPRD      = 7'h36;
  localparam logic [6:0] A_RFLT      = 7'h38;
  localparam logic [6:0] A_SLEEP     = 7'h3A;
  localparam logic [6:0] A_DIAG      = 7'h3C;
  localparam logic [6:0] A_GCMD      = 7'h3E;
  localparam logic [6:0] A_LOT1      = 7'h52;
  localparam logic [6:0] A_LOT2      = 7'h54;
  localparam logic [6:0] A_PROD      = 7'h56;
  localparam logic [6:0] A_SERIAL    = 7'h58;

  // global command bits
  localparam int GC_AUTONULL   = 0;
  localparam int GC_FLASH_SAVE = 3;

  // writable word slots
  localparam int         NSLOT   = 14;
  localparam logic [3:0] S_ANGLE = 4'h0;
  localparam logic [3:0] S_OFF   = 4'h1;
  localparam logic [3:0] S_SCALE = 4'h2;
  localparam logic [3:0] S_MAG1  = 4'h3;
  localparam logic [3:0] S_MAG2  = 4'h4;
  localparam logic [3:0] S_SMPL1 = 4'h5;
  localparam logic [3:0] S_SMPL2 = 4'h6;
  localparam logic [3:0] S_ALMC  = 4'h7;
  localparam logic [3:0] S_DAC   = 4'h8;
  localparam logic [3:0] S_DIO   = 4'h9;
  localparam logic [3:0] S_MISC  = 4'hA;
  localparam logic [3:0] S_SPRD  = 4'hB;
  localparam logic [3:0] S_RFLT  = 4'hC;
  localparam logic [3:0] S_SLEEP = 4'hD;

  // reset values
  localparam logic [15:0] RST_ZERO  = 16'h0000;
  localparam logic [15:0] RST_SPRD  = 16'h0001;
  localparam logic [15:0] RST_RFLT  = 16'h0402;
  localparam logic [15:0] RST_SCALE = 16'h0800;

  // word address (either byte) to {hit, slot}
  function automatic logic [4:0] slot_of(input logic [6:0] a);
    logic [6:0] w;
    w = {a[6:1], 1'b0};
    unique case (w)
      A_ANGLE:    slot_of = {1'b1, S_ANGLE};
      A_OFF:      slot_of = {1'b1, S_OFF};
      A_SCALE:    slot_of = {1'b1, S_SCALE};
      A_MAG1:     slot_of = {1'b1, S_MAG1};
      A_MAG2:     slot_of = {1'b1, S_MAG2};
      A_SMPL1:    slot_of = {1'b1, S_SMPL1};
      A_SMPL2:    slot_of = {1'b1, S_SMPL2};
      A_ALARM_CONTROL: slot_of = {1'b1, S_ALMC};
      A_DAC:      slot_of = {1'b1, S_DAC};
      A_DIO:      slot_of = {1'b1, S_DIO};
      A_MISC:     slot_of = {1'b1, S_MISC};
      A_SPRD:     slot_of = {1'b1, S_SPRD};
      A_RFLT:     slot_of = {1'b1, S_RFLT};
      A_SLEEP:    slot_of = {1'b1, S_SLEEP};
      default:    slot_of = 5'h00;
    endcase
  endfunction : slot_of

  function automatic logic slot_flash(input logic [3:0] s);
    slot_flash = !(s == S_ANGLE || s == S_DAC || s == S_DIO);
  endfunction : slot_flash

  function automatic logic [15:0] slot_default(input logic [3:0] s);
    unique case (s)
      S_SCALE: slot_default = RST_SCALE;
      S_SPRD:  slot_default = RST_SPRD;
      S_RFLT:  slot_default = RST_RFLT;
      default: slot_default = RST_ZERO;
    endcase
  endfunction : slot_default

  // host side timing
  localparam int SYS_CLK_HZ  = 100_000_000;
  localparam int SCLK_MAX_HZ = 2_500_000;
  localparam int SCLK_HALF_CYC =
    (SYS_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int STALL_NS  = 9000;
  localparam int STALL_CYC =
    (STALL_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

  // host command port offsets
  localparam logic [7:0] H_CMD  = 8'h00;
  localparam logic [7:0] H_STAT = 8'h04;
  localparam logic [7:0] H_RX   = 8'h08;

endpackage : gsr_pkg

// ---- src/gsr_spi_if.sv ----
// four-wire serial link between the gyro and its master
`timescale 1ns/1ns
`default_nettype none
interface gsr_spi_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  modport dev  (input cs_n, input sclk, input mosi, output miso);
  modport host (output cs_n, output sclk, output mosi, input miso);
endinterface : gsr_spi_if
`default_nettype wire

// ---- src/gsr_dev.sv ----
// gyro serial slave with user register map
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module gsr_dev
  import gsr_pkg::*;
#(
  parameter logic [15:0] PRODUCT_CODE = 16'h1234, // arbitrary value
  parameter logic [15:0] LOT_CODE1    = 16'h0000,
  parameter logic [15:0] LOT_CODE2    = 16'h0000,
  parameter logic [15:0] SERIAL_CODE  = 16'h0000
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        powerup_n_in,
  // serial link
  gsr_spi_if.dev           spi,
  // measurements from the sensor path
  input  wire logic [15:0] supply_in,
  input  wire logic [15:0] rate_in,
  input  wire logic [15:0] aux_in,
  input  wire logic [15:0] temp_in,
  input  wire logic [15:0] diag_in,
  input  wire logic [15:0] angle_in,
  input  wire logic        angle_load_in,
  // configuration and actions
  output var  logic [15:0] cfg_out [NSLOT],
  output logic [15:0]      flash_count_out,
  output logic             autonull_out,
  output logic             flash_save_out
);

  logic [2:0]  s1_q, s2_q, s3_q, f_q, fp_q;
  logic [4:0]  bit_q;
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic [15:0] resp_q;
  logic        done_q;
  logic        miso_q;
  logic [15:0] work_q  [NSLOT];
  logic [15:0] flash_q [NSLOT];
  logic [15:0] fcnt_q;
  logic [15:0] rd_word;
  logic [4:0]  hit;
  logic        cs_fall, sclk_rise, sclk_fall, active;
  logic        wr_go, rd_go;
  logic [6:0]  fr_addr;
  logic [7:0]  fr_data;

  // three-stage sampling; a change counts once stages two and three agree
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      s1_q <= SY_IDLE;
      s2_q <= SY_IDLE;
      s3_q <= SY_IDLE;
      f_q  <= SY_IDLE;
      fp_q <= SY_IDLE;
    end else begin
      s1_q <= {spi.cs_n, spi.sclk, spi.mosi};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
      fp_q <= f_q;
    end
  end

  assign active    = !f_q[SY_CS];
  assign cs_fall   = fp_q[SY_CS] && !f_q[SY_CS];
  assign sclk_rise = active && f_q[SY_SCLK] && !fp_q[SY_SCLK];
  assign sclk_fall = active && !f_q[SY_SCLK] && fp_q[SY_SCLK];

  // shift in msb first; frame ends on the sixteenth rising edge
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      bit_q  <= 5'h00;
      rx_q   <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!active) begin
        bit_q <= 5'h00;
      end else if (sclk_rise && bit_q != BIT_CNT_FULL) begin
        rx_q  <= {rx_q[FRAME_BITS-2:0], f_q[SY_MOSI]};
        bit_q <= bit_q + 5'h01;
        done_q <= (bit_q == BIT_CNT_LAST);
      end
    end
  end

  assign fr_addr = rx_q[FR_ADDR_HI:FR_ADDR_LO];
  assign fr_data = rx_q[FR_DATA_HI:0];
  assign wr_go   = done_q && rx_q[FR_RW];
  assign rd_go   = done_q && !rx_q[FR_RW];
  assign hit     = slot_of(fr_addr);

  // whole word for either byte address; reserved reads as zero
  always_comb begin
    rd_word = 16'h0000;
    if (hit[4]) begin
      rd_word = work_q[hit[3:0]];
    end else begin
      unique case ({fr_addr[6:1], 1'b0})
        A_FLASH_WRITE_COUNT: rd_word = fcnt_q;
        A_SUPPLY:    rd_word = supply_in;
        A_RATE:      rd_word = rate_in;
        A_AUX:       rd_word = aux_in;
        A_TEMP:      rd_word = temp_in;
        A_DIAG:      rd_word = diag_in;
        A_LOT1:      rd_word = LOT_CODE1;
        A_LOT2:      rd_word = LOT_CODE2;
        A_PROD:      rd_word = PRODUCT_CODE;
        A_SERIAL:    rd_word = SERIAL_CODE;
        default:     rd_word = 16'h0000;
      endcase
    end
  end

  // answer is staged for the next frame, so reads pipeline
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      resp_q <= 16'h0000;
    end else if (rd_go) begin
      resp_q <= rd_word;
    end else if (wr_go) begin
      resp_q <= 16'h0000;
    end
  end

  // output changes on falling edges; msb presented at select
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      tx_q   <= 16'h0000;
      miso_q <= 1'b0;
    end else if (cs_fall) begin
      tx_q   <= resp_q;
      miso_q <= resp_q[FRAME_BITS-1];
    end else if (sclk_fall) begin
      miso_q <= tx_q[FRAME_BITS-1];
    end else if (sclk_rise) begin
      tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
    end
  end

  assign spi.miso = miso_q;

  // working registers; one byte per frame
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < NSLOT; i++) begin
        work_q[i] <= slot_flash(4'(i)) ? flash_q[i]
                                       : slot_default(4'(i));
      end
    end else begin
      if (angle_load_in) begin
        work_q[S_ANGLE] <= angle_in;
      end
      // host write wins over a sensor update in the same cycle
      if (wr_go && hit[4]) begin
        if (fr_addr[0]) begin
          work_q[hit[3:0]][15:8] <= fr_data;
        end else begin
          work_q[hit[3:0]][7:0] <= fr_data;
        end
      end
    end
  end

  // global command: lower byte holds the action bits
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      autonull_out   <= 1'b0;
      flash_save_out <= 1'b0;
    end else begin
      autonull_out   <= wr_go && fr_addr == A_GCMD
                        && fr_data[GC_AUTONULL];
      flash_save_out <= wr_go && fr_addr == A_GCMD
                        && fr_data[GC_FLASH_SAVE];
    end
  end

  // nonvolatile copy; loaded with slot defaults and count cleared only at power-up, kept across reset
  always_ff @(posedge sys_clk_in) begin
    if (!powerup_n_in) begin
      for (int i = 0; i < NSLOT; i++) begin
        flash_q[i] <= slot_default(4'(i));
      end
      fcnt_q <= 16'h0000;
    end else if (flash_save_out) begin
      for (int i = 0; i < NSLOT; i++) begin
        if (slot_flash(4'(i))) begin
          flash_q[i] <= work_q[i];
        end
      end
      fcnt_q <= fcnt_q + 16'h0001;
    end
  end

  assign cfg_out         = work_q;
  assign flash_count_out = fcnt_q;

endmodule : gsr_dev
`default_nettype wire

// ---- src/gsr_host.sv ----
// serial master that issues one 16-bit frame per command write accepted while idle
`timescale 1ns/1ns
`default_nettype none
module gsr_host
  import gsr_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  // command port
  input  wire logic [7:0]  addr_in,
  input  wire logic [15:0] wr_data_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [15:0]      rd_data_out,
  // serial link
  gsr_spi_if.host          spi
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_STALL = 3'b100
  } gsr_state_e;

  gsr_state_e  st_q;
  logic [9:0]  cnt_q;
  logic [4:0]  bit_q;
  logic [15:0] tx_q, rsh_q, rx_q;
  logic        cs_n_q, sclk_q, mosi_q;
  logic        m1_q, m2_q, m3_q, mf_q;
  logic        start;

  localparam logic [9:0] HALF_LAST  = 10'(SCLK_HALF_CYC - 1);
  localparam logic [9:0] STALL_LAST = 10'(STALL_CYC - 1);

  // miso comes from another domain: three stages, agree to accept
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      m1_q <= 1'b0;
      m2_q <= 1'b0;
      m3_q <= 1'b0;
      mf_q <= 1'b0;
    end else begin
      m1_q <= spi.miso;
      m2_q <= m1_q;
      m3_q <= m2_q;
      if (m2_q == m3_q) begin
        mf_q <= m3_q;
      end
    end
  end

  // a command written while busy is dropped
  assign start = wr_in && addr_in == H_CMD && st_q == ST_IDLE;

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      st_q   <= ST_IDLE;
      cnt_q  <= 10'h000;
      bit_q  <= 5'h00;
      tx_q   <= 16'h0000;
      rsh_q  <= 16'h0000;
      rx_q   <= 16'h0000;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b1;
      mosi_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (start) begin
            tx_q   <= wr_data_in;
            mosi_q <= wr_data_in[FRAME_BITS-1];
            cs_n_q <= 1'b0;
            bit_q  <= 5'h00;
            cnt_q  <= 10'h000;
            st_q   <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (cnt_q != HALF_LAST) begin
            cnt_q <= cnt_q + 10'h001;
          end else begin
            cnt_q <= 10'h000;
            if (sclk_q && bit_q == BIT_CNT_FULL) begin
              cs_n_q <= 1'b1;
              rx_q   <= rsh_q;
              st_q   <= ST_STALL;
            end else if (sclk_q) begin
              sclk_q <= 1'b0;
              mosi_q <= tx_q[FRAME_BITS-1];
            end else begin
              sclk_q <= 1'b1;
              rsh_q  <= {rsh_q[FRAME_BITS-2:0], mf_q};
              tx_q   <= {tx_q[FRAME_BITS-2:0], 1'b0};
              bit_q  <= bit_q + 5'h01;
            end
          end
        end
        ST_STALL: begin
          // gap lets the device stage its answer
          if (cnt_q != STALL_LAST) begin
            cnt_q <= cnt_q + 10'h001;
          end else begin
            cnt_q <= 10'h000;
            st_q  <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // status bit 0 is busy
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      rd_data_out <= 16'h0000;
    end else if (rd_in) begin
      unique case (addr_in)
        H_STAT:  rd_data_out <= {15'h0000, st_q != ST_IDLE};
        H_RX:    rd_data_out <= rx_q;
        default: rd_data_out <= 16'h0000;
      endcase
    end
  end

  assign spi.cs_n = cs_n_q;
  assign spi.sclk = sclk_q;
  assign spi.mosi = mosi_q;

endmodule : gsr_host
`default_nettype wire

// ---- sim/gsr_link_props.sv ----
// wire-level assertions on the gyro serial link
`timescale 1ns/1ns
`default_nettype none
module gsr_link_props
  import gsr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // serial link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso
);
  logic        sclk_q;
  logic [4:0]  rise_q;
  logic [15:0] gap_q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  always_ff @(posedge sys_clk_in) begin
    sclk_q <= resetn_in ? sclk : 1'b1;
  end

  // rising edges seen in the current frame
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in || cs_n)
      rise_q <= 5'h00;
    else if (sclk && !sclk_q)
      rise_q <= rise_q + 5'h01;
  end

  // idle cycles since the last frame; starts saturated so reset is no gap
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in)
      gap_q <= 16'hFFFF;
    else if (!cs_n)
      gap_q <= 16'h0000;
    else if (gap_q != 16'hFFFF)
      gap_q <= gap_q + 16'h0001;
  end

  sequence low_half;
    !sclk [*8] ##1 !sclk [*8] ##1 !sclk [*4];
  endsequence
  sequence high_half;
    sclk [*8] ##1 sclk [*8] ##1 sclk [*4];
  endsequence

  idle_clock_high_a: assert property (cs_n |-> sclk)
    else $error("serial clock low while deselected");
  lead_in_a: assert property (
    $fell(cs_n) |-> sclk [*8] ##13 $fell(sclk))
    else $error("first clock fall not 20 cycles after select");
  low_half_a: assert property ($fell(sclk) |-> low_half ##1 sclk)
    else $error("serial clock low phase not 20 cycles");
  high_half_a: assert property ($rose(sclk) |-> high_half)
    else $error("serial clock high phase too short");
  mosi_hold_a: assert property (
    !cs_n && !$past(cs_n) && sclk && sclk_q |-> $stable(mosi))
    else $error("master data moved while clock high");
  miso_hold_a: assert property (
    !cs_n && sclk && sclk_q && rise_q != 5'h00 && rise_q != 5'h10
    |-> $stable(miso)) else $error("device data moved while clock high");
  bit_count_a: assert property ($rose(cs_n) |-> rise_q == 5'h10)
    else $error("frame without sixteen clock edges");
  stall_gap_a: assert property ($fell(cs_n) |-> gap_q >= STALL_CYC)
    else $error("frames closer than the stall time");
endmodule : gsr_link_props
`default_nettype wire

// ---- sim/gyro_spi_register_access_tb.sv ----
// self-checking bench: host and gyro ends joined over the serial link
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  failures++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module gyro_spi_register_access_tb
  import gsr_pkg::*;
;
  localparam logic [15:0] PCODE = 16'hC3A5; // arbitrary value
  localparam logic [13:0] FL    = 14'h3CFE;
  localparam logic [6:0]  WA [NSLOT] = '{A_ANGLE, A_OFF, A_SCALE, A_MAG1,
    A_MAG2, A_SMPL1, A_SMPL2, A_ALARM_CONTROL, A_DAC, A_DIO, A_MISC, A_SPRD,
    A_RFLT, A_SLEEP};
  // reads touch listed addresses only
  localparam logic [6:0]  RA [10] = '{A_SUPPLY, A_RATE | 7'h01, A_RATE,
    A_AUX | 7'h01, A_TEMP, A_DIAG, A_PROD, A_GCMD, A_FLASH_WRITE_COUNT,
    A_LOT2 | 7'h01};
  logic        sys_clk_in    = 1'b0;
  logic        resetn_in     = 1'b0;
  logic        powerup_n_in  = 1'b0;
  logic [7:0]  addr_in       = 8'h00;
  logic [15:0] wr_data_in    = 16'h0000;
  logic        wr_in         = 1'b0;
  logic        rd_in         = 1'b0;
  logic [15:0] angle_in      = 16'h0000;
  logic        angle_load_in = 1'b0;
  logic        sclk_p        = 1'b1;
  logic [15:0] rd_data_out, flash_count_out, sh_o, sh_i, pend, fc;
  logic [15:0] sens [5];
  logic [15:0] cfg_out [NSLOT];
  logic [15:0] m [NSLOT];
  logic [15:0] f [NSLOT];
  logic        autonull_out, flash_save_out;
  int          failures = 0, num_checks = 0, n_null = 0, n_save = 0;
  int          since = 0, en = 0, es = 0, s;

  gsr_spi_if spi ();
  gsr_host u_gsr_host (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out), .spi(spi));
  gsr_dev #(.PRODUCT_CODE(PCODE)) u_gsr_dev (.sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in), .powerup_n_in(powerup_n_in), .spi(spi),
    .supply_in(sens[0]), .rate_in(sens[1]), .aux_in(sens[2]),
    .temp_in(sens[3]), .diag_in(sens[4]), .angle_in(angle_in),
    .angle_load_in(angle_load_in), .cfg_out(cfg_out),
    .flash_count_out(flash_count_out), .autonull_out(autonull_out),
    .flash_save_out(flash_save_out));
  gsr_link_props u_gsr_link_props (.sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in), .cs_n(spi.cs_n), .sclk(spi.sclk),
    .mosi(spi.mosi), .miso(spi.miso));

  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // wire monitor: bits sampled on serial clock rises, msb first
  always @(posedge sys_clk_in) begin
    sclk_p <= spi.sclk;
    since <= since + 1;
    if (!spi.cs_n && spi.sclk && !sclk_p) begin
      sh_o <= {sh_o[14:0], spi.mosi};
      sh_i <= {sh_i[14:0], spi.miso};
      since <= 0;
    end
    if (autonull_out === 1'b1) begin
      n_null <= n_null + 1;
      `CHK("start delay", 1'b1, since < 8)
    end
    if (flash_save_out === 1'b1)
      n_save <= n_save + 1;
  end

  function automatic logic [15:0] dflt(input int k);
    return k == 2 ? 16'h0800 : k == 11 ? 16'h0001 :
      k == 12 ? 16'h0402 : 16'h0000;
  endfunction : dflt

  // word the device should return for a request frame
  function automatic logic [15:0] model(input logic [15:0] w);
    logic [6:0] a;
    a = {w[14:9], 1'b0};
    if (w[15])
      return 16'h0000;
    for (int k = 0; k < NSLOT; k++)
      if (WA[k] == a)
        return m[k];
    case (a)
      A_FLASH_WRITE_COUNT: return fc;
      A_SUPPLY:    return sens[0];
      A_RATE:      return sens[1];
      A_AUX:       return sens[2];
      A_TEMP:      return sens[3];
      A_DIAG:      return sens[4];
      A_PROD:      return PCODE;
      default:     return 16'h0000;
    endcase
  endfunction : model

  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    tick(1);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    addr_in <= a;
    rd_in <= 1'b1;
    tick(1);
    rd_in <= 1'b0;
    tick(1);
    d = rd_data_out;
  endtask : rd

  task automatic chk_cfg();
    for (int k = 0; k < NSLOT; k++)
      `CHK("cfg", m[k], cfg_out[k])
  endtask : chk_cfg

  // one frame; checks what came back against the previous request
  task automatic go(input logic [15:0] w);
    logic [15:0] nx, st, rx;
    int k;
    nx = model(w);
    wr(H_CMD, w);
    st = 16'h0001;
    for (k = 0; k < 2000 && st[0] !== 1'b0; k++)
      rd(H_STAT, st);
    if (k >= 2000) begin
      failures++;
      test_done();
    end
    rd(H_RX, rx);
    `CHK("rx word", pend, rx)
    `CHK("wire in", pend, sh_i)
    `CHK("wire out", w, sh_o)
    pend = nx;
    if (w[15]) begin
      for (int j = 0; j < NSLOT; j++)
        if (WA[j] == {w[14:9], 1'b0}) begin
          if (w[8])
            m[j][15:8] = w[7:0];
          else
            m[j][7:0] = w[7:0];
        end
      if (w[14:8] == A_GCMD) begin
        en += w[GC_AUTONULL];
        if (w[GC_FLASH_SAVE]) begin
          es++;
          fc++;
          for (int j = 0; j < NSLOT; j++)
            f[j] = FL[j] ? m[j] : f[j];
        end
      end
    end
    chk_cfg();
    `CHK("autonull", en, n_null)
    `CHK("save", es, n_save)
    `CHK("flash count", fc, flash_count_out)
  endtask : go

  task automatic do_reset(input logic pwr);
    resetn_in <= 1'b0;
    powerup_n_in <= !pwr;
    tick(5);
    resetn_in <= 1'b1;
    powerup_n_in <= 1'b1;
    tick(6);
    for (int k = 0; k < NSLOT; k++) begin
      if (pwr)
        f[k] = dflt(k);
      m[k] = FL[k] ? f[k] : dflt(k);
    end
    if (pwr)
      fc = 16'h0000;
    pend = 16'h0000;
    chk_cfg();
  endtask : do_reset

  initial begin
    s = $urandom(32'h9EE1EB9E);
    for (int k = 0; k < 5; k++)
      sens[k] = 16'h0000;
    do_reset(1'b1);
    // defaults read back, pipelined, odd slots by upper byte address
    for (int k = 0; k < NSLOT; k++)
      go({1'b0, WA[k] | 7'(k & 1), 8'h00});
    $display("test defaults done");
    repeat (10) begin
      s = $urandom_range(NSLOT - 1);
      go({1'b1, WA[s] | 7'($urandom_range(1)), 8'($urandom)});
    end
    $display("test byte writes done");
    for (int k = 0; k < 5; k++)
      sens[k] <= 16'($urandom);
    tick(1);
    for (int i = 0; i < 10; i++)
      go({1'b0, RA[i], 8'h00});
    $display("test reads done");
    // refused writes: read-only, identity, command upper byte; then an angle byte write and a sensor load
    go({1'b1, A_RATE, 8'hFF});
    go({1'b1, A_TEMP | 7'h01, 8'hFF});
    go({1'b1, A_PROD | 7'h01, 8'hFF});
    go({1'b1, A_GCMD | 7'h01, 8'hFF});
    go({1'b1, A_ANGLE, 8'h5A});
    angle_in <= 16'($urandom);
    angle_load_in <= 1'b1;
    tick(1);
    angle_load_in <= 1'b0;
    tick(2);
    m[S_ANGLE] = angle_in;
    chk_cfg();
    $display("test refused and angle done");
    go(16'hBE01);
    go(16'hBE08);
    go(16'hBE09);
    go({1'b1, A_OFF, 8'hA5});
    go({1'b1, A_DAC | 7'h01, 8'h3C});
    go({1'b0, A_FLASH_WRITE_COUNT | 7'h01, 8'h00});
    do_reset(1'b0);
    go({1'b0, A_FLASH_WRITE_COUNT, 8'h00});
    go({1'b0, A_OFF, 8'h00});
    go({1'b0, A_PROD, 8'h00});
    go({1'b0, A_SERIAL | 7'h01, 8'h00});
    $display("test commands and flash done");
    test_done();
  end
endmodule : gyro_spi_register_access_tb
`default_nettype wire
